/* hdl/dtp_pkg.sv */
package dtp_pkg;
	typedef logic [9:0] dtp_cnt_t;
	typedef logic [7:0] dtp_byte_t;
	typedef logic [2:0] dtp_ratio_t;
	typedef logic [7:0] dtp_addr_t;
	typedef logic [31:0] dtp_word_t;
	typedef logic [3:0] dtp_sel_t;

	localparam int DTP_TIMERS = 2;
	localparam int DTP_PWMS = 3;

	// register map, byte addresses; timer B block sits one stride above timer A
	localparam dtp_addr_t TMR_STRIDE = 8'h20;
	localparam dtp_addr_t OFF_CTRL1 = 8'h00;
	localparam dtp_addr_t OFF_CTRL2 = 8'h04;
	localparam dtp_addr_t OFF_RELOAD_LOW = 8'h08;
	localparam dtp_addr_t OFF_HIGH = 8'h0C;
	localparam dtp_addr_t OFF_DUTY_LOW = 8'h10;
	localparam dtp_addr_t OFF_PS_VALUE = 8'h14;
	localparam dtp_addr_t OFF_PWMB_CTRL = 8'h40;
	localparam dtp_addr_t OFF_PWMB_DUTY_LOW = 8'h44;
	localparam dtp_addr_t OFF_BUZZER = 8'h48;
	localparam dtp_addr_t OFF_IRQ_FLAG = 8'h4C;
	localparam dtp_addr_t OFF_IRQ_ENABLE = 8'h50;

	// primary control fields
	localparam int BIT_RUN = 0;
	localparam int BIT_RELOAD_SEL = 1;
	localparam int BIT_ONE_SHOT = 2;
	localparam int BIT_ACTIVE_LOW = 6;
	localparam int BIT_OUT_EN = 7;
	// clock and prescale control fields
	localparam int BIT_CLK_SEL = 5;
	localparam int BIT_EDGE_SEL = 4;
	localparam int BIT_PS_EN_N = 3;
	// high bits register fields
	localparam int HI_RELOAD_LSB = 4;
	localparam int HI_DUTY_A_LSB = 0;
	localparam int HI_DUTY_B_LSB = 2;
	// buzzer fields
	localparam int BIT_BZ_EN = 7;
	localparam int BIT_BZ_SRC = 3;
	// interrupt fields
	localparam int BIT_FLAG_A = 3;
	localparam int BIT_FLAG_B = 4;
	localparam int BIT_IE_A = 3;
	localparam int BIT_IE_B = 0;
	localparam int BIT_GIE = 7;
	localparam dtp_byte_t IRQ_EN_MASK = 8'h89;

	localparam dtp_byte_t CTRL_RST = 8'h00;
	localparam dtp_cnt_t COUNT_RST = 10'h000;
	localparam dtp_cnt_t RELOAD_FREE = 10'h3FF;
	localparam dtp_cnt_t DUTY_NONE = 10'h000;
	// instruction clock is the core clock divided by four
	localparam logic [1:0] INSTR_DIV_LAST = 2'h3;

	// mask of low bits that must be all ones for a 1:2^(r+1) wrap
	function automatic dtp_byte_t ratio_mask(input dtp_ratio_t r);
		ratio_mask = dtp_byte_t'((9'h002 << r) - 9'h001);
	endfunction : ratio_mask
endpackage : dtp_pkg

/* hdl/dtp_timer.sv */
`timescale 1ns/1ps
module dtp_timer (
	input logic core_clk,
	input logic sys_rst,
	input logic instrTick,
	input logic extPin,
	input logic run,
	input logic clkSel,
	input logic edgeSel,
	input logic prescaleEnN,
	input dtp_pkg::dtp_ratio_t ratio,
	input logic oneShot,
	input logic reloadSel,
	input dtp_pkg::dtp_cnt_t reloadValue,
	input logic loadNow,
	output dtp_pkg::dtp_cnt_t count,
	output dtp_pkg::dtp_byte_t prescaleValue,
	output logic prescaleTick,
	output logic underflow
);
	import dtp_pkg::*;

	logic pinPrev_reg;
	dtp_cnt_t count_reg;
	dtp_cnt_t count_next;
	dtp_byte_t psCnt_reg;
	dtp_byte_t psCnt_next;
	logic stopped_reg;
	logic stopped_next;

	// pin edges; the pin is taken as already synchronous to core_clk
	wire riseEdge = extPin & ~pinPrev_reg;
	wire fallEdge = ~extPin & pinPrev_reg;
	wire srcTick = clkSel ? (edgeSel ? fallEdge : riseEdge) : instrTick;
	wire dtp_byte_t psMask = ratio_mask(ratio);
	wire psWrap = srcTick && ((psCnt_reg & psMask) == psMask);
	wire stageTick = run && (prescaleEnN ? srcTick : psWrap);
	wire cntTick = stageTick && !stopped_reg;
	wire uflow = cntTick && (count_reg == COUNT_RST);

	// counter next value; a direct load beats any tick in the same cycle
	always_comb begin
		count_next = count_reg;
		if (loadNow) begin
			count_next = reloadValue;
		end else if (uflow) begin
			count_next = (reloadSel || oneShot) ? reloadValue : RELOAD_FREE;
		end else if (cntTick) begin
			count_next = count_reg - 10'h001;
		end
	end

	// prescaler is held clear while bypassed so it restarts from zero when inserted
	assign psCnt_next = (!run || prescaleEnN) ? 8'h00 : (srcTick ? psCnt_reg + 8'h01 : psCnt_reg);
	// one-shot halt lasts until the timer is stopped or reloaded by software
	assign stopped_next = (!run || loadNow) ? 1'b0 : (stopped_reg || (uflow && oneShot));

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pinPrev_reg <= 1'b0;
			count_reg <= COUNT_RST;
			psCnt_reg <= 8'h00;
			stopped_reg <= 1'b0;
		end else begin
			pinPrev_reg <= extPin;
			count_reg <= count_next;
			psCnt_reg <= psCnt_next;
			stopped_reg <= stopped_next;
		end
	end

	assign count = count_reg;
	assign prescaleValue = psCnt_reg;
	assign prescaleTick = stageTick;
	assign underflow = uflow;

	a_free_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
		uflow && !oneShot && !reloadSel && !loadNow |=> count_reg == RELOAD_FREE)
		else $error("non-stop restart is not 0x3FF");
	a_stored_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
		uflow && reloadSel && !loadNow |=> count_reg == $past(reloadValue))
		else $error("underflow did not take the reload value");
	a_load_now: assert property (@(posedge core_clk) disable iff (sys_rst)
		loadNow |=> count_reg == $past(reloadValue))
		else $error("direct load missed");
	a_hold_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		!run && !loadNow |=> $stable(count_reg))
		else $error("stopped timer moved");
	a_one_shot_halt: assert property (@(posedge core_clk) disable iff (sys_rst)
		(uflow && oneShot) ##1 (run && !loadNow) |=> $stable(count_reg))
		else $error("one-shot timer kept counting");
	a_down_step: assert property (@(posedge core_clk) disable iff (sys_rst)
		cntTick && (count_reg != COUNT_RST) && !loadNow |=> count_reg == $past(count_reg) - 10'h001)
		else $error("count did not step down by one");
endmodule : dtp_timer

/* hdl/dtp_top.sv */
`timescale 1ns/1ps
module dtp_top (
	input logic core_clk,
	input logic sys_rst,
	input dtp_pkg::dtp_addr_t wb_adr_i,
	input dtp_pkg::dtp_word_t wb_dat_i,
	input dtp_pkg::dtp_sel_t wb_sel_i,
	input logic wb_we_i,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	output dtp_pkg::dtp_word_t wb_dat_o,
	output logic wb_ack_o,
	input logic extClockAPin,
	input logic extClockBPin,
	output logic sharedPinOut,
	output logic sharedPinOe,
	output logic pwmAAltOut,
	output logic pwmAAltOe,
	output logic pwmBOut,
	output logic pwmBOe,
	output logic pwmCOut,
	output logic pwmCOe,
	output logic irqRequestA,
	output logic irqRequestB
);
	import dtp_pkg::*;

	// bus state
	logic ack_reg;
	dtp_word_t rdData_reg;
	// per timer registers
	dtp_byte_t ctrl1_reg [DTP_TIMERS];
	dtp_byte_t ctrl2_reg [DTP_TIMERS];
	dtp_byte_t hi_reg [DTP_TIMERS];
	dtp_cnt_t reloadPend_reg [DTP_TIMERS];
	logic loadNow_reg [DTP_TIMERS];
	// per channel duty buffers: 0 PWM A, 1 PWM C, 2 PWM B
	dtp_cnt_t dutyPend_reg [DTP_PWMS];
	dtp_cnt_t dutyAct_reg [DTP_PWMS];
	logic pwmOut_reg [DTP_PWMS];
	logic pwmOe_reg [DTP_PWMS];
	// shared registers
	dtp_byte_t pwmBCtrl_reg;
	dtp_byte_t bzCtrl_reg;
	dtp_byte_t bzCnt_reg;
	logic bzLevel_reg;
	logic sharedOut_reg;
	logic sharedOe_reg;
	dtp_byte_t irqFlag_reg;
	dtp_byte_t irqFlag_next;
	dtp_byte_t irqEn_reg;
	logic irqReqA_reg;
	logic irqReqB_reg;
	logic [1:0] instrDiv_reg;
	logic instrTick_reg;

	// timer outputs
	dtp_cnt_t tmrCount [DTP_TIMERS];
	dtp_byte_t tmrPsVal [DTP_TIMERS];
	logic tmrPsTick [DTP_TIMERS];
	logic tmrUflow [DTP_TIMERS];
	dtp_byte_t tmrRd [DTP_TIMERS];
	logic wrCtrl1 [DTP_TIMERS];
	logic wrCtrl2 [DTP_TIMERS];
	logic wrReloadLow [DTP_TIMERS];
	logic wrHigh [DTP_TIMERS];
	// per channel views
	dtp_cnt_t chCount [DTP_PWMS];
	logic chUflow [DTP_PWMS];
	logic chOen [DTP_PWMS];
	logic chPol [DTP_PWMS];
	logic [1:0] chHi [DTP_PWMS];
	logic wrDuty [DTP_PWMS];
	logic lvlNext [DTP_PWMS];

	// bus decode; a request is taken once, in the cycle before ack
	wire wbReq = wb_cyc_i && wb_stb_i && !ack_reg;
	wire wbWr = wbReq && wb_we_i && wb_sel_i[0];
	wire dtp_byte_t wbByte = wb_dat_i[7:0];
	wire wrPwmBCtrl = wbWr && (wb_adr_i == OFF_PWMB_CTRL);
	wire wrPwmBDuty = wbWr && (wb_adr_i == OFF_PWMB_DUTY_LOW);
	wire wrBuzzer = wbWr && (wb_adr_i == OFF_BUZZER);
	wire wrIrqFlag = wbWr && (wb_adr_i == OFF_IRQ_FLAG);
	wire wrIrqEn = wbWr && (wb_adr_i == OFF_IRQ_ENABLE);

	// instruction clock enable, one pulse every fourth core cycle
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			instrDiv_reg <= 2'h0;
			instrTick_reg <= 1'b0;
		end else begin
			instrDiv_reg <= instrDiv_reg + 2'h1;
			instrTick_reg <= (instrDiv_reg == INSTR_DIV_LAST);
		end
	end

	genvar t;
	generate
		for (t = 0; t < DTP_TIMERS; t++) begin : g_tmr
			localparam dtp_addr_t BASE = dtp_addr_t'(t) * TMR_STRIDE;
			wire adCtrl1 = (wb_adr_i == BASE + OFF_CTRL1);
			wire adCtrl2 = (wb_adr_i == BASE + OFF_CTRL2);
			wire adReload = (wb_adr_i == BASE + OFF_RELOAD_LOW);
			wire adHigh = (wb_adr_i == BASE + OFF_HIGH);
			wire adDuty = (wb_adr_i == BASE + OFF_DUTY_LOW);
			wire adPs = (wb_adr_i == BASE + OFF_PS_VALUE);
			wire runBit = ctrl1_reg[t][BIT_RUN];

			assign wrCtrl1[t] = wbWr && adCtrl1;
			assign wrCtrl2[t] = wbWr && adCtrl2;
			assign wrReloadLow[t] = wbWr && adReload;
			assign wrHigh[t] = wbWr && adHigh;

			// reads of the reload pair return the live count, not the buffer
			assign tmrRd[t] = adCtrl1 ? ctrl1_reg[t] :
				adCtrl2 ? ctrl2_reg[t] :
				adReload ? tmrCount[t][7:0] :
				adHigh ? {2'b00, tmrCount[t][9:8], hi_reg[t][3:0]} :
				adDuty ? dutyPend_reg[t][7:0] :
				adPs ? tmrPsVal[t] :
				8'h00;

			// reload buffer forms on the low byte write from the high bits written before
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					ctrl1_reg[t] <= CTRL_RST;
					ctrl2_reg[t] <= CTRL_RST;
					hi_reg[t] <= CTRL_RST;
					reloadPend_reg[t] <= COUNT_RST;
					loadNow_reg[t] <= 1'b0;
				end else begin
					if (wrCtrl1[t]) begin
						ctrl1_reg[t] <= wbByte;
					end
					if (wrCtrl2[t]) begin
						ctrl2_reg[t] <= wbByte;
					end
					if (wrHigh[t]) begin
						hi_reg[t] <= wbByte;
					end
					if (wrReloadLow[t]) begin
						reloadPend_reg[t] <= {hi_reg[t][HI_RELOAD_LSB +: 2], wbByte};
					end
					// delayed a cycle so the timer sees the freshly formed buffer
					loadNow_reg[t] <= wrReloadLow[t] && !runBit;
				end
			end

			dtp_timer u_timer (
				.core_clk(core_clk),
				.sys_rst(sys_rst),
				.instrTick(instrTick_reg),
				.extPin(t == 0 ? extClockAPin : extClockBPin),
				.run(runBit),
				.clkSel(ctrl2_reg[t][BIT_CLK_SEL]),
				.edgeSel(ctrl2_reg[t][BIT_EDGE_SEL]),
				.prescaleEnN(ctrl2_reg[t][BIT_PS_EN_N]),
				.ratio(ctrl2_reg[t][2:0]),
				.oneShot(ctrl1_reg[t][BIT_ONE_SHOT]),
				.reloadSel(ctrl1_reg[t][BIT_RELOAD_SEL]),
				.reloadValue(reloadPend_reg[t]),
				.loadNow(loadNow_reg[t]),
				.count(tmrCount[t]),
				.prescaleValue(tmrPsVal[t]),
				.prescaleTick(tmrPsTick[t]),
				.underflow(tmrUflow[t])
			);
		end
	endgenerate

	// channel wiring: PWM A and B share timer A, PWM C runs on timer B
	assign chCount[0] = tmrCount[0];
	assign chCount[1] = tmrCount[1];
	assign chCount[2] = tmrCount[0];
	assign chUflow[0] = tmrUflow[0];
	assign chUflow[1] = tmrUflow[1];
	assign chUflow[2] = tmrUflow[0];
	assign chOen[0] = ctrl1_reg[0][BIT_OUT_EN];
	assign chOen[1] = ctrl1_reg[1][BIT_OUT_EN];
	assign chOen[2] = pwmBCtrl_reg[BIT_OUT_EN];
	assign chPol[0] = ctrl1_reg[0][BIT_ACTIVE_LOW];
	assign chPol[1] = ctrl1_reg[1][BIT_ACTIVE_LOW];
	assign chPol[2] = pwmBCtrl_reg[BIT_ACTIVE_LOW];
	assign chHi[0] = hi_reg[0][HI_DUTY_A_LSB +: 2];
	assign chHi[1] = hi_reg[1][HI_DUTY_A_LSB +: 2];
	assign chHi[2] = hi_reg[0][HI_DUTY_B_LSB +: 2];
	assign wrDuty[0] = wbWr && (wb_adr_i == OFF_DUTY_LOW);
	assign wrDuty[1] = wbWr && (wb_adr_i == TMR_STRIDE + OFF_DUTY_LOW);
	assign wrDuty[2] = wrPwmBDuty;

	genvar c;
	generate
		for (c = 0; c < DTP_PWMS; c++) begin : g_pwm
			// active while the down count sits below the duty value, so duty 0 never fires
			assign lvlNext[c] = chOen[c] && ((chCount[c] < dutyAct_reg[c]) ^ chPol[c]);

			// duty is double buffered; a period never sees a half-written value
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					dutyPend_reg[c] <= DUTY_NONE;
					dutyAct_reg[c] <= DUTY_NONE;
					pwmOut_reg[c] <= 1'b0;
					pwmOe_reg[c] <= 1'b0;
				end else begin
					if (wrDuty[c]) begin
						dutyPend_reg[c] <= {chHi[c], wbByte};
					end
					if (chUflow[c]) begin
						dutyAct_reg[c] <= dutyPend_reg[c];
					end
					pwmOut_reg[c] <= lvlNext[c];
					pwmOe_reg[c] <= chOen[c];
				end
			end
		end
	endgenerate

	// buzzer divider; source is timer A underflow or its prescaler output
	wire bzOn = bzCtrl_reg[BIT_BZ_EN];
	wire bzSrc = bzCtrl_reg[BIT_BZ_SRC] ? tmrUflow[0] : tmrPsTick[0];
	wire dtp_byte_t bzMask = ratio_mask(bzCtrl_reg[2:0]);
	wire bzWrap = bzSrc && ((bzCnt_reg & bzMask) == bzMask);
	wire dtp_byte_t bzCnt_next = !bzOn ? 8'h00 : (bzSrc ? bzCnt_reg + 8'h01 : bzCnt_reg);

	// shared pin: PWM A first, buzzer only when PWM A is off
	wire sharedOut_next = chOen[0] ? lvlNext[0] : (bzOn && bzLevel_reg);
	wire sharedOe_next = chOen[0] || bzOn;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pwmBCtrl_reg <= CTRL_RST;
			bzCtrl_reg <= CTRL_RST;
			bzCnt_reg <= 8'h00;
			bzLevel_reg <= 1'b0;
			sharedOut_reg <= 1'b0;
			sharedOe_reg <= 1'b0;
		end else begin
			if (wrPwmBCtrl) begin
				pwmBCtrl_reg <= wbByte;
			end
			if (wrBuzzer) begin
				bzCtrl_reg <= wbByte;
			end
			bzCnt_reg <= bzCnt_next;
			bzLevel_reg <= bzOn && (bzLevel_reg ^ bzWrap);
			sharedOut_reg <= sharedOut_next;
			sharedOe_reg <= sharedOe_next;
		end
	end

	// sticky flags: a write of 0 clears, a same-cycle underflow still sets
	always_comb begin
		irqFlag_next = irqFlag_reg;
		if (wrIrqFlag && !wbByte[BIT_FLAG_A]) begin
			irqFlag_next[BIT_FLAG_A] = 1'b0;
		end
		if (wrIrqFlag && !wbByte[BIT_FLAG_B]) begin
			irqFlag_next[BIT_FLAG_B] = 1'b0;
		end
		if (tmrUflow[0]) begin
			irqFlag_next[BIT_FLAG_A] = 1'b1;
		end
		if (tmrUflow[1]) begin
			irqFlag_next[BIT_FLAG_B] = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irqFlag_reg <= CTRL_RST;
			irqEn_reg <= CTRL_RST;
			irqReqA_reg <= 1'b0;
			irqReqB_reg <= 1'b0;
		end else begin
			irqFlag_reg <= irqFlag_next;
			if (wrIrqEn) begin
				irqEn_reg <= wbByte & IRQ_EN_MASK;
			end
			irqReqA_reg <= irqFlag_reg[BIT_FLAG_A] && irqEn_reg[BIT_IE_A] && irqEn_reg[BIT_GIE];
			irqReqB_reg <= irqFlag_reg[BIT_FLAG_B] && irqEn_reg[BIT_IE_B] && irqEn_reg[BIT_GIE];
		end
	end

	// read selection; unmapped addresses answer zero
	wire dtp_byte_t miscRd = (wb_adr_i == OFF_PWMB_CTRL) ? pwmBCtrl_reg :
		(wb_adr_i == OFF_PWMB_DUTY_LOW) ? dutyPend_reg[2][7:0] :
		(wb_adr_i == OFF_BUZZER) ? bzCtrl_reg :
		(wb_adr_i == OFF_IRQ_FLAG) ? irqFlag_reg :
		(wb_adr_i == OFF_IRQ_ENABLE) ? irqEn_reg :
		8'h00;
	wire dtp_byte_t rdByte = tmrRd[0] | tmrRd[1] | miscRd;

	// one-cycle ack for every access, mapped or not
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
			rdData_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= wbReq;
			rdData_reg <= wbReq ? {24'h00_0000, rdByte} : 32'h0000_0000;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdData_reg;
	assign sharedPinOut = sharedOut_reg;
	assign sharedPinOe = sharedOe_reg;
	assign pwmAAltOut = pwmOut_reg[0];
	assign pwmAAltOe = pwmOe_reg[0];
	assign pwmCOut = pwmOut_reg[1];
	assign pwmCOe = pwmOe_reg[1];
	assign pwmBOut = pwmOut_reg[2];
	assign pwmBOe = pwmOe_reg[2];
	assign irqRequestA = irqReqA_reg;
	assign irqRequestB = irqReqB_reg;

	a_ack_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_flag_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		tmrUflow[0] |=> irqFlag_reg[BIT_FLAG_A])
		else $error("underflow A did not set its flag");
	a_flag_hold_b: assert property (@(posedge core_clk) disable iff (sys_rst)
		irqFlag_reg[BIT_FLAG_B] && !(wrIrqFlag && !wbByte[BIT_FLAG_B]) |=> irqFlag_reg[BIT_FLAG_B])
		else $error("flag B dropped without a clearing write");
	a_gie_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
		!irqEn_reg[BIT_GIE] [*2] |-> !irqRequestA && !irqRequestB)
		else $error("request raised with global enable off");
	a_duty_apply: assert property (@(posedge core_clk) disable iff (sys_rst)
		chUflow[0] |=> dutyAct_reg[0] == $past(dutyPend_reg[0]))
		else $error("PWM A duty not applied at underflow");
	a_duty_apply_c: assert property (@(posedge core_clk) disable iff (sys_rst)
		!chUflow[1] |=> $stable(dutyAct_reg[1]))
		else $error("PWM C duty changed outside underflow");
	a_duty_never: assert property (@(posedge core_clk) disable iff (sys_rst)
		(dutyAct_reg[0] == DUTY_NONE) && chOen[0] |=> pwmOut_reg[0] == $past(chPol[0]))
		else $error("zero duty produced an active level");
	a_shared_prio: assert property (@(posedge core_clk) disable iff (sys_rst)
		chOen[0] |=> sharedPinOut == pwmAAltOut && sharedPinOe && pwmAAltOe)
		else $error("shared pin not following PWM A");
endmodule : dtp_top

/* dv/tb_dual_downcount_timer_pwm_buzzer.sv */
`timescale 1ns/1ps
module tb_dual_downcount_timer_pwm_buzzer;
	import dtp_pkg::*;
	logic core_clk, sys_rst, we, cyc, stb, ack, extA, extB;
	dtp_addr_t adr;
	dtp_word_t datW, datR;
	dtp_sel_t sel;
	logic shOut, shOe, altOut, altOe, bOut, bOe, cOut, cOe, irqA, irqB;
	int failures;
	int check_count;
	dtp_byte_t expQ[$];
	dtp_byte_t expNow;
	logic [31:0] seed;
	dtp_cnt_t rl;

	// free-running core clock, 5 ns period
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	dtp_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_adr_i(adr), .wb_dat_i(datW), .wb_sel_i(sel),
		.wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(datR), .wb_ack_o(ack), .extClockAPin(extA),
		.extClockBPin(extB), .sharedPinOut(shOut), .sharedPinOe(shOe), .pwmAAltOut(altOut), .pwmAAltOe(altOe),
		.pwmBOut(bOut), .pwmBOe(bOe), .pwmCOut(cOut), .pwmCOe(cOe), .irqRequestA(irqA), .irqRequestB(irqB));

	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xorshift = y ^ (y << 5);
	endfunction : xorshift

	// classic single cycle; request held until ack is sampled, then released
	task automatic bus(input dtp_addr_t a, input dtp_byte_t d, input logic w);
		int n;
		@(posedge core_clk);
		adr <= a;
		datW <= {24'h00_0000, d};
		we <= w;
		cyc <= 1'b1;
		stb <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) begin
			failures++;
			$display("BAD %0t no bus answer", $time);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : bus

	task automatic wr(input dtp_addr_t a, input dtp_byte_t d);
		bus(a, d, 1'b1);
	endtask : wr
	// expectation noted before the cycle; the monitor compares it at the ack
	task automatic rd(input dtp_addr_t a, input dtp_byte_t e);
		expQ.push_back(e);
		bus(a, 8'h00, 1'b0);
	endtask : rd
	task automatic chk(input logic got, input logic exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t pin %s", $time, what);
		end
	endtask : chk
	// one high pulse on the timer B pin, long enough to be sampled both ways
	task automatic pulse();
		@(posedge core_clk);
		extB <= 1'b1;
		repeat (6) @(posedge core_clk);
		extB <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask : pulse
	task automatic test_done();
		repeat (3) @(posedge core_clk);
		if (expQ.size() != 0) begin
			failures++;
			$display("BAD %0t reads left unanswered", $time);
		end
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	// read data monitor: we is still held at the ack edge, so reads are told apart
	always @(posedge core_clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			check_count++;
			if (expQ.size() == 0) begin
				failures++;
				$display("BAD %0t unexpected read answer", $time);
			end else begin
				expNow = expQ.pop_front();
				if (datR !== {24'h00_0000, expNow}) begin
					failures++;
					$display("BAD %0t read %h expected %h", $time, datR, expNow);
				end
			end
		end
	end
	// a hang ends the run through the same closing task
	initial begin
		repeat (20000) @(posedge core_clk);
		failures++;
		$display("BAD %0t watchdog expired", $time);
		test_done();
	end

	initial begin
		failures = 0;
		check_count = 0;
		seed = 32'h0000_001A;
		sys_rst = 1'b1;
		{adr, datW, we, cyc, stb, extA, extB} = '0;
		sel = 4'hF;
		repeat (10) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(8'h00, 8'h00);
		rd(8'h4C, 8'h00);
		rd(8'h50, 8'h00);
		// unmapped place: write ignored, read zero
		wr(8'h3C, 8'h5A);
		rd(8'h3C, 8'h00);
		// stopped timer A: low byte write loads counter at once, reads give live count
		seed = xorshift(seed);
		rl = seed[9:0];
		wr(8'h0C, {2'b00, rl[9:8], 4'h0});
		wr(8'h08, rl[7:0]);
		rd(8'h08, rl[7:0]);
		rd(8'h0C, {2'b00, rl[9:8], 4'h0});
		// one-shot from 3 on the instruction clock, interrupt first masked by global enable
		wr(8'h0C, 8'h00);
		wr(8'h08, 8'h03);
		wr(8'h04, 8'h08);
		wr(8'h50, 8'h08);
		wr(8'h00, 8'h05);
		repeat (40) @(posedge core_clk);
		rd(8'h4C, 8'h08);
		chk(irqA, 1'b0, "irq A masked");
		wr(8'h50, 8'h88);
		repeat (3) @(posedge core_clk);
		chk(irqA, 1'b1, "irq A request");
		rd(8'h08, 8'h03);
		rd(8'h08, 8'h03);
		wr(8'h4C, 8'h00);
		rd(8'h4C, 8'h00);
		chk(irqA, 1'b0, "irq A cleared");
		// PWM A and B enabled active low with zero duty: pins driven and idle high
		wr(8'h40, 8'hC0);
		wr(8'h48, 8'h80);
		wr(8'h00, 8'hC0);
		repeat (3) @(posedge core_clk);
		chk(bOe, 1'b1, "pwm B oe");
		chk(bOut, 1'b1, "pwm B level");
		chk(shOe, 1'b1, "shared oe");
		chk(shOut, 1'b1, "shared level");
		chk(altOe, 1'b1, "alt oe");
		chk(altOut, 1'b1, "alt level");
		// timer B on falling pin edges, non-stop from 0x3FF, duty C pending 0x3FF
		wr(8'h2C, 8'h00);
		wr(8'h28, 8'h02);
		wr(8'h24, 8'h38);
		wr(8'h2C, 8'h03);
		wr(8'h30, 8'hFF);
		wr(8'h50, 8'h81);
		wr(8'h20, 8'h81);
		pulse();
		rd(8'h28, 8'h01);
		chk(cOe, 1'b1, "pwm C oe");
		chk(cOut, 1'b0, "pwm C old duty");
		pulse();
		pulse();
		rd(8'h28, 8'hFF);
		rd(8'h2C, 8'h33);
		rd(8'h4C, 8'h10);
		chk(irqB, 1'b1, "irq B request");
		chk(cOut, 1'b0, "pwm C at 3FF");
		pulse();
		chk(cOut, 1'b1, "pwm C new duty");
		// rising edges instead
		wr(8'h24, 8'h28);
		pulse();
		rd(8'h28, 8'hFD);
		// prescaler inserted at 1:2: one step for every two rising edges
		wr(8'h24, 8'h20);
		pulse();
		rd(8'h34, 8'h01);
		pulse();
		rd(8'h28, 8'hFC);
		test_done();
	end
endmodule : tb_dual_downcount_timer_pwm_buzzer
